/* File: bfm_pkg.sv */
// Purpose: shared types and constants of the two-way queue block
// Assumes: one system clock samples both port clocks
// Notes:   offsets X are presets picked at reset release
`default_nettype none
package bfm_pkg;

	localparam int         DATA_W  = 36;
	localparam int         DEPTH   = 64;
	localparam int         PTR_W   = 7;
	localparam logic [6:0] FULL_CNT = 7'h40;
	localparam logic [6:0] ZERO_CNT = 7'h00;
	// Offset presets for almost flags, picked by the two offset selects
	localparam logic [6:0] OFS_X0  = 7'h10;
	localparam logic [6:0] OFS_X1  = 7'h0C;
	localparam logic [6:0] OFS_X2  = 7'h08;
	localparam logic [6:0] OFS_X3  = 7'h04;
	localparam int         BYTE_W  = 9;
	localparam int         NBYTES  = 4;
	localparam int         PAR_BIT = 8;
	localparam int         SYNC_N  = 3;

	typedef struct packed {
		logic              clock;
		logic              select_n;
		logic              enable;
		logic              write;
		logic              mailbox_select;
		logic              parity_gen;
		logic [35:0]       data;
	} bfm_port_in_t;

	typedef struct packed {
		logic [35:0]       data;
		logic              data_oe;
		logic              empty_n;
		logic              full_n;
		logic              almost_empty_n;
		logic              almost_full_n;
		logic              parity_error_n;
		logic              mail_flag_n;
	} bfm_port_out_t;

endpackage
`default_nettype wire

/* File: bfm_top.sv */
// Purpose: two opposite 64x36 queues with mailboxes, parity, flags
// Assumes: port clocks are slow pins sampled by CLK
// Notes:   index 0 is port A, 1 is port B; queue q is written by port q
`timescale 1ns/1ns
`default_nettype none

module bfm_top
	import bfm_pkg::*;
(
	input  wire logic          CLK,
	input  wire logic          RST,
	input  wire logic          CE,
	input  wire logic          ODD_PARITY,
	input  wire logic          OFFSET_SELECT_LOW,
	input  wire logic          OFFSET_SELECT_HIGH,
	input  wire bfm_port_in_t  PORT_A_IN,
	input  wire bfm_port_in_t  PORT_B_IN,
	output var  bfm_port_out_t PORT_A_OUT,
	output var  bfm_port_out_t PORT_B_OUT
);

	function automatic logic par_ok(input logic [35:0] d, input logic odd);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < NBYTES; i++) begin
			if ((^d[i*BYTE_W +: BYTE_W]) != odd) ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic logic [35:0] par_gen(input logic [35:0] d,
		input logic odd);
		logic [35:0] r;
		r = d;
		for (int i = 0; i < NBYTES; i++) begin
			r[i*BYTE_W + PAR_BIT] = odd ^ (^d[i*BYTE_W +: PAR_BIT]);
		end
		return r;
	endfunction

	function automatic logic [6:0] preset(input logic hi, input logic lo);
		case ({hi, lo})
			2'b00: return OFS_X0;
			2'b01: return OFS_X1;
			2'b10: return OFS_X2;
			default: return OFS_X3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Pin sampling: three stages, change accepted when 2nd and 3rd agree
	bfm_port_in_t s1_r [2];
	bfm_port_in_t s2_r [2];
	bfm_port_in_t s3_r [2];
	logic         clk_lvl_r [2];
	logic         edge_c [2];
	logic         wr_c [2];
	logic         rd_c [2];
	bfm_port_in_t pin [2];

	assign pin[0] = PORT_A_IN;
	assign pin[1] = PORT_B_IN;

	always_ff @(posedge CLK) begin
		for (int p = 0; p < 2; p++) begin
			if (RST) begin
				s1_r[p] <= '0;
				s2_r[p] <= '0;
				s3_r[p] <= '0;
				clk_lvl_r[p] <= 1'b0;
			end else if (CE) begin
				s1_r[p] <= pin[p];
				s2_r[p] <= s1_r[p];
				s3_r[p] <= s2_r[p];
				if (s2_r[p].clock == s3_r[p].clock)
					clk_lvl_r[p] <= s3_r[p].clock;
			end
		end
	end

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			edge_c[p] = s2_r[p].clock & s3_r[p].clock & ~clk_lvl_r[p];
			// Select low and enable high qualify the edge
			wr_c[p] = edge_c[p] & ~s3_r[p].select_n & s3_r[p].enable
				& s3_r[p].write;
			rd_c[p] = edge_c[p] & ~s3_r[p].select_n & s3_r[p].enable
				& ~s3_r[p].write;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Offset X caught one cycle after reset release
	logic       rst_d_r;
	logic [6:0] x_r;

	always_ff @(posedge CLK) begin
		if (RST) begin
			rst_d_r <= 1'b1;
			x_r <= OFS_X0;
		end else if (CE) begin
			rst_d_r <= 1'b0;
			if (rst_d_r)
				x_r <= preset(OFFSET_SELECT_HIGH, OFFSET_SELECT_LOW);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Queues: q=0 A to B, q=1 B to A
	logic [35:0] mem_r [2][DEPTH];
	logic [6:0]  wp_r [2];
	logic [6:0]  rp_r [2];
	logic [6:0]  cnt [2];
	logic [6:0]  free [2];
	logic [35:0] oreg_r [2];
	logic        push [2];
	logic        pop [2];
	logic        full_n_r [2];
	logic        empty_n_r [2];
	logic        f1_r [2];
	logic        af1_r [2];
	logic        e1_r [2];
	logic        ae1_r [2];
	logic        aempty_n_r [2];
	logic        afull_n_r [2];

	always_comb begin
		for (int q = 0; q < 2; q++) begin
			cnt[q] = wp_r[q] - rp_r[q];
			free[q] = FULL_CNT - cnt[q];
			// Raw count also guards the flag lag
			push[q] = wr_c[q] & ~s3_r[q].mailbox_select
				& full_n_r[q] & (cnt[q] != FULL_CNT);
			pop[q] = rd_c[q^1] & ~s3_r[q^1].mailbox_select
				& empty_n_r[q^1] & (cnt[q] != ZERO_CNT);
		end
	end

	always_ff @(posedge CLK) begin
		for (int q = 0; q < 2; q++) begin
			if (CE && push[q])
				mem_r[q][wp_r[q][5:0]] <= s3_r[q].data;
		end
	end

	always_ff @(posedge CLK) begin
		for (int q = 0; q < 2; q++) begin
			if (RST) begin
				wp_r[q] <= ZERO_CNT;
				rp_r[q] <= ZERO_CNT;
				oreg_r[q] <= '0;
			end else if (CE) begin
				// Push and pop on one edge both proceed
				if (push[q])
					wp_r[q] <= wp_r[q] + 7'h01;
				if (pop[q]) begin
					rp_r[q] <= rp_r[q] + 7'h01;
					oreg_r[q] <= mem_r[q][rp_r[q][5:0]];
				end
			end
		end
	end

	// Flags for port p: full side of queue p, empty side of queue p^1
	always_ff @(posedge CLK) begin
		for (int p = 0; p < 2; p++) begin
			if (RST) begin
				f1_r[p] <= 1'b0;
				af1_r[p] <= 1'b0;
				full_n_r[p] <= 1'b0;
				afull_n_r[p] <= 1'b0;
				e1_r[p] <= 1'b0;
				ae1_r[p] <= 1'b0;
				empty_n_r[p] <= 1'b0;
				aempty_n_r[p] <= 1'b0;
			end else if (CE && edge_c[p]) begin
				f1_r[p] <= cnt[p] != FULL_CNT;
				full_n_r[p] <= f1_r[p];
				af1_r[p] <= free[p] > x_r;
				afull_n_r[p] <= af1_r[p];
				e1_r[p] <= cnt[p^1] != ZERO_CNT;
				empty_n_r[p] <= e1_r[p];
				ae1_r[p] <= cnt[p^1] > x_r;
				aempty_n_r[p] <= ae1_r[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Mailboxes: mbox q written by port q, read by port q^1
	logic [35:0] mail_r [2];
	logic        mf_n_r [2];
	logic        mb_wr [2];
	logic        mb_rd [2];

	always_comb begin
		for (int q = 0; q < 2; q++) begin
			mb_wr[q] = wr_c[q] & s3_r[q].mailbox_select & mf_n_r[q];
			mb_rd[q] = rd_c[q^1] & s3_r[q^1].mailbox_select;
		end
	end

	always_ff @(posedge CLK) begin
		for (int q = 0; q < 2; q++) begin
			if (RST) begin
				mail_r[q] <= '0;
				mf_n_r[q] <= 1'b1;
			end else if (CE) begin
				if (mb_wr[q]) begin
					mail_r[q] <= s3_r[q].data;
					mf_n_r[q] <= 1'b0;
				end else if (mb_rd[q]) begin
					mf_n_r[q] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Port outputs, all from flops
	logic [35:0] dout_r [2];
	logic        oe_r [2];
	logic        perr_n_r [2];
	logic [35:0] rsel [2];

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			rsel[p] = s3_r[p].mailbox_select ? mail_r[p^1] : oreg_r[p^1];
		end
	end

	always_ff @(posedge CLK) begin
		for (int p = 0; p < 2; p++) begin
			if (RST) begin
				dout_r[p] <= '0;
				oe_r[p] <= 1'b0;
				perr_n_r[p] <= 1'b1;
			end else if (CE) begin
				dout_r[p] <= s3_r[p].parity_gen
					? par_gen(rsel[p], ODD_PARITY) : rsel[p];
				oe_r[p] <= ~s3_r[p].select_n & ~s3_r[p].write;
				// Shared parity tree busy generating on a mailbox read: flag forced high
				if (~s3_r[p].write & s3_r[p].mailbox_select
					& s3_r[p].parity_gen)
					perr_n_r[p] <= 1'b1;
				else
					perr_n_r[p] <= par_ok(s3_r[p].data, ODD_PARITY);
			end
		end
	end

	always_comb begin
		PORT_A_OUT = '{dout_r[0], oe_r[0], empty_n_r[0], full_n_r[0],
			aempty_n_r[0], afull_n_r[0], perr_n_r[0], mf_n_r[0]};
		PORT_B_OUT = '{dout_r[1], oe_r[1], empty_n_r[1], full_n_r[1],
			aempty_n_r[1], afull_n_r[1], perr_n_r[1], mf_n_r[1]};
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_count_max;
		cnt[0] <= FULL_CNT && cnt[1] <= FULL_CNT;
	endproperty
	a_count_max: assert property (p_count_max) else $error("count over 64");

	property p_both_ways;
		CE && push[0] && pop[0] |=> $stable(cnt[0]);
	endproperty
	a_both_ways: assert property (p_both_ways) else $error("push+pop lost");

	property p_qual;
		push[0] |-> !s3_r[0].select_n && s3_r[0].enable && edge_c[0];
	endproperty
	a_qual: assert property (p_qual) else $error("unqualified push");

	property p_float_a;
		CE && s3_r[0].select_n |=> !PORT_A_OUT.data_oe;
	endproperty
	a_float_a: assert property (p_float_a) else $error("A drives unselected");

	property p_float_b;
		CE && s3_r[1].select_n |=> !PORT_B_OUT.data_oe;
	endproperty
	a_float_b: assert property (p_float_b) else $error("B drives unselected");

	property p_pop_gate;
		pop[1] |-> PORT_A_OUT.empty_n;
	endproperty
	a_pop_gate: assert property (p_pop_gate) else $error("read while empty");

	property p_empty_two;
		CE && $rose(empty_n_r[0]) |-> $past(e1_r[0]) && $past(edge_c[0]);
	endproperty
	a_empty_two: assert property (p_empty_two) else $error("empty rose early");

	property p_mail_low;
		CE && mb_wr[0] |=> !PORT_A_OUT.mail_flag_n;
	endproperty
	a_mail_low: assert property (p_mail_low) else $error("mail flag stuck");

	property p_mail_hold;
		CE && !mf_n_r[0] && !mb_rd[0] |=> $stable(mail_r[0]) && !mf_n_r[0];
	endproperty
	a_mail_hold: assert property (p_mail_hold) else $error("mail overwritten");

	property p_ae_a;
		CE && edge_c[0] && (cnt[1] <= x_r) |=> !ae1_r[0];
	endproperty
	a_ae_a: assert property (p_ae_a) else $error("A almost-empty wrong");

	c_full: cover property (cnt[0] == FULL_CNT);
	c_both: cover property (push[1] && pop[1]);
	c_mail: cover property (mb_wr[0] ##[1:200] mb_rd[0]);
	c_afull: cover property (!PORT_B_OUT.almost_full_n);

endmodule // bfm_top
`default_nettype wire

/* File: bfm_host.sv */
// Purpose: far-side bus master for one port of the queue block
// Assumes: one transfer at a time; shares CLK with the device
// Notes:   fixed holds, since the port gives no handshake back
`timescale 1ns/1ns
`default_nettype none
module bfm_host
	import bfm_pkg::*;
(
	input  wire bfm_port_out_t PORT_OUT,
	input  wire logic          CLK,
	output var  bfm_port_in_t  PORT_IN
);
////////////////////////////////////////////////////////////////////////
initial begin
	PORT_IN = '0;
	PORT_IN.select_n = 1'b1;
end
// One port clock pulse; sel_n high makes an idle edge
task automatic xfer(input logic w, input logic mb, input logic sel_n,
	input logic pg, input logic [35:0] d, output bfm_port_out_t s);
	@(posedge CLK);
	PORT_IN.select_n <= sel_n;
	PORT_IN.parity_gen <= pg;
	PORT_IN.enable <= 1'b1;
	PORT_IN.write <= w;
	PORT_IN.mailbox_select <= mb;
	PORT_IN.data <= d;
	repeat (4) @(posedge CLK);
	PORT_IN.clock <= 1'b1;
	repeat (5) @(posedge CLK);
	@(negedge CLK);
	s = PORT_OUT;
	@(posedge CLK);
	PORT_IN.clock <= 1'b0;
	repeat (4) @(posedge CLK);
	// Released bus must not keep showing the old word
	PORT_IN.select_n <= 1'b1;
	PORT_IN.enable <= 1'b0;
	PORT_IN.data <= ~d;
endtask
endmodule // bfm_host
`default_nettype wire

/* File: bfm_tb_top.sv */
// Purpose: self-checking bench for the two-way queue block
// Assumes: starts with CE high, even parity, offset select 00 (X = 16)
// Notes:   port B host reads what port A writes and back
`timescale 1ns/1ns
`default_nettype none
module bfm_tb_top;
	import bfm_pkg::*;
typedef struct {
	logic        b2a;
	logic        mb;
	logic [35:0] d;
	logic        pok;
} bfm_row_t;
logic          clk;
logic          rst;
bfm_port_in_t  pa_in;
bfm_port_in_t  pb_in;
bfm_port_out_t pa_out;
bfm_port_out_t pb_out;
bfm_port_out_t s;
bfm_port_out_t s_b;
logic          ce;
logic          odd;
logic          ofs_lo;
logic          ofs_hi;
logic          pg;
int            err_total;
int            tests_run;
bfm_row_t      rows [4];
////////////////////////////////////////////////////////////////////////
bfm_top i_dut (.CLK(clk), .RST(rst), .CE(ce), .ODD_PARITY(odd),
	.OFFSET_SELECT_LOW(ofs_lo), .OFFSET_SELECT_HIGH(ofs_hi),
	.PORT_A_IN(pa_in), .PORT_B_IN(pb_in),
	.PORT_A_OUT(pa_out), .PORT_B_OUT(pb_out));
bfm_host i_host_a (.CLK(clk), .PORT_OUT(pa_out), .PORT_IN(pa_in));
bfm_host i_host_b (.CLK(clk), .PORT_OUT(pb_out), .PORT_IN(pb_in));
////////////////////////////////////////////////////////////////////////
task automatic chk(input string n, input logic [35:0] seen,
	input logic [35:0] exp);
	tests_run++;
	if (seen !== exp) begin
		err_total++;
		$display("BAD %s exp %h seen %h", n, exp, seen);
	end
endtask
task automatic chkb(input string n, input logic seen, input logic exp);
	chk(n, {35'h0, seen}, {35'h0, exp});
endtask
task automatic op(input logic pb, input logic w, input logic mb,
	input logic sel_n, input logic [35:0] d);
	if (pb) begin
		i_host_b.xfer(w, mb, sel_n, pg, d, s);
	end else begin
		i_host_a.xfer(w, mb, sel_n, pg, d, s);
	end
endtask
task automatic give_verdict();
	$display("checks %0d mismatches %0d", tests_run, err_total);
	if (err_total == 0 && tests_run > 0) begin
		$display("DONE - PASS");
	end else begin
		$display("DONE - FAIL");
	end
	$finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	clk = 1'b0;
	forever #25 clk = ~clk;
end
initial begin
	#2000000;
	err_total++;
	give_verdict();
end
initial begin
	err_total = 0;
	tests_run = 0;
	ce = 1'b1;
	odd = 1'b0;
	ofs_lo = 1'b0;
	ofs_hi = 1'b0;
	pg = 1'b0;
	rst = 1'b1;
	// Last field: expected parity flag under even parity
	rows = '{'{1'b0, 1'b0, 36'h000000003, 1'b1},
		'{1'b1, 1'b0, 36'h000000001, 1'b0},
		'{1'b0, 1'b1, 36'hFFFFFFFFF, 1'b0},
		'{1'b1, 1'b1, 36'h0000001FE, 1'b1}};
	repeat (16) @(posedge clk);
	rst <= 1'b0;
	@(negedge clk);
	chkb("a_empty", pa_out.empty_n, 1'b0);
	chkb("a_full", pa_out.full_n, 1'b0);
	chkb("b_oe", pb_out.data_oe, 1'b0);
	chkb("a_mail", pa_out.mail_flag_n, 1'b1);
	repeat (2) begin
		op(0, 0, 0, 1, 0);
		op(1, 0, 0, 1, 0);
	end
	chkb("b_oe", s.data_oe, 1'b0);
	chkb("a_full", pa_out.full_n, 1'b1);
	chkb("b_full", pb_out.full_n, 1'b1);
	chkb("a_afull", pa_out.almost_full_n, 1'b1);
	chkb("b_afull", pb_out.almost_full_n, 1'b1);
	$display("reset test done");
	foreach (rows[r]) begin
		op(rows[r].b2a, 1, rows[r].mb, 0, rows[r].d);
		chkb("par", s.parity_error_n, rows[r].pok);
		if (rows[r].mb) begin
			chkb("mail", s.mail_flag_n, 1'b0);
		end else begin
			op(!rows[r].b2a, 0, 0, 1, 0);
			chkb("empty", s.empty_n, 1'b0);
			op(!rows[r].b2a, 0, 0, 1, 0);
			chkb("empty", s.empty_n, 1'b1);
		end
		op(!rows[r].b2a, 0, rows[r].mb, 0, ~rows[r].d);
		chk("rd", s.data, rows[r].d);
		chkb("oe", s.data_oe, 1'b1);
		if (rows[r].mb) begin
			chkb("mail", rows[r].b2a ? pb_out.mail_flag_n :
				pa_out.mail_flag_n, 1'b1);
		end
		$display("row %0d done", r);
	end
	// Second mail word must bounce while the first is unread
	op(0, 1, 1, 0, 36'h000000005);
	op(0, 1, 1, 0, 36'h00000000A);
	op(1, 0, 1, 0, 36'h0);
	chk("mail_keep", s.data, 36'h000000005);
	$display("mailbox hold test done");
	for (int i = 0; i < 65; i++) begin
		op(0, 1, 0, 0, 36'(i));
	end
	repeat (2) op(0, 0, 0, 1, 0);
	chkb("a_full", pa_out.full_n, 1'b0);
	chkb("a_afull", pa_out.almost_full_n, 1'b0);
	repeat (2) op(1, 0, 0, 1, 0);
	chkb("b_aempty", pb_out.almost_empty_n, 1'b1);
	for (int i = 0; i < 65; i++) begin
		op(1, 0, 0, 0, 0);
		chk("fill_rd", s.data, 36'(i < 64 ? i : 63));
	end
	repeat (2) op(1, 0, 0, 1, 0);
	chkb("b_empty", pb_out.empty_n, 1'b0);
	chkb("b_aempty", pb_out.almost_empty_n, 1'b0);
	$display("fill test done");
	// Parity insertion on a queue word, then on mail under odd parity
	repeat (2) op(0, 0, 0, 1, 0);
	op(0, 1, 0, 0, 36'h000000001);
	repeat (2) op(1, 0, 0, 1, 0);
	pg = 1'b1;
	op(1, 0, 0, 0, 36'h0);
	chk("pgen_q", s.data, 36'h000000101);
	odd <= 1'b1;
	op(1, 0, 1, 0, 36'h0);
	chk("pgen_mb", s.data, 36'h804020105);
	chkb("perr_forced", s.parity_error_n, 1'b1);
	pg = 1'b0;
	op(0, 0, 0, 1, 36'h0);
	chkb("perr_odd", s.parity_error_n, 1'b0);
	$display("parity test done");
	// Mid-run reset with the smallest offset preset, X = 4
	ofs_lo <= 1'b1;
	ofs_hi <= 1'b1;
	rst <= 1'b1;
	repeat (2) @(posedge clk);
	rst <= 1'b0;
	@(negedge clk);
	chkb("a_full_rst", pa_out.full_n, 1'b0);
	chkb("b_empty_rst", pb_out.empty_n, 1'b0);
	repeat (2) begin
		op(0, 0, 0, 1, 0);
		op(1, 0, 0, 1, 0);
	end
	for (int i = 1; i < 6; i++) begin
		op(0, 1, 0, 0, 36'(i));
	end
	repeat (2) op(1, 0, 0, 1, 0);
	chkb("b_aempty_x", pb_out.almost_empty_n, 1'b1);
	$display("offset test done");
	// Frozen clock enable: a port read must neither act nor drive
	ce <= 1'b0;
	op(0, 0, 0, 0, 0);
	chkb("ce_oe", s.data_oe, 1'b0);
	ce <= 1'b1;
	$display("enable test done");
	// A write and B read on one edge: count must hold at five
	fork
		i_host_a.xfer(1, 0, 0, 1'b0, 36'h000000006, s);
		i_host_b.xfer(0, 0, 0, 1'b0, 36'h0, s_b);
	join
	chk("both_rd", s_b.data, 36'h000000001);
	repeat (2) op(1, 0, 0, 1, 0);
	chkb("b_aempty_both", pb_out.almost_empty_n, 1'b1);
	$display("same edge test done");
	give_verdict();
end
endmodule // bfm_tb_top
`default_nettype wire
